// *** tbsem_pkg.sv ***
// Shared constants, types and state codes for the two-wire bus sharing block.
// Assumes one bus clock for both ends; the shared access lines and acknowledge are resolved by tbsem_if.
// Contract
// R1 - Partner raises hold, then drives access lines.
// R2 - During partner access, request and driven stay inactive; request can still go active in the partner's start cycle.
// R3 - Line width code gives four data beats.
// R4 - Address and direction captured once, then ignored.
// R5 - Partner drives start for exactly one cycle.
// R6 - Select and byte enables asserted in cycle four.
// R7 - Zero wait: acknowledge from cycle five, each beat.
// R8 - Selects held; partner keeps in-progress till last beat.
// R9 - Acknowledge and in-progress both drop after last beat.
// R10 - Select and byte enables released closing the access.
// R11 - Share bus with one partner, no arbiter.
// R12 - Partner holds request only while needing bus.
// R13 - Grant plus pending request: drive driven, explicit master.
// R14 - Explicit master starts cycle, keeps driving while granted.
// R15 - Grant removed: finish cycle, then release bus.
// R16 - Burst series counts as one bus cycle.
// R17 - Granted without request: implicit master, bus undriven.
// R18 - Request during implicit mastership starts access at once.
// R19 - Transfer may start cycle after grant.
// R20 - Partner never grants while itself driving.
// R21 - Partner drives start, never address strobe.
// R22 - Partner hits need select enable; use select settings.
// R23 - Reset keeps bus released and driven inactive.
package tbsem_pkg;
  // Address and attribute lines of one bus access.
  typedef struct packed {
    logic [31:0] addr;
    logic rw;
    logic [1:0] width;
    logic [1:0] ttype;
    logic [2:0] tmod;
  } tbsem_attr_t;
  // Level of the attribute lines when nobody drives them.
  localparam tbsem_attr_t ATTR_IDLE = tbsem_attr_t'(40'hFFFFFFFFFF);
  // Transfer width codes.
  localparam logic [1:0] WIDTH_LONG = 2'h0;
  localparam logic [1:0] WIDTH_BYTE = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;
  localparam logic [1:0] WIDTH_LINE = 2'h3;
  // Beats of a line access and of a single access.
  localparam logic [2:0] LINE_BEATS = 3'h4;
  localparam logic [2:0] SINGLE_BEATS = 3'h1;
  // Register offsets.
  localparam logic [11:0] OFF_CMD = 12'h000;
  localparam logic [11:0] OFF_ADDR = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_SEL_BASE = 12'h010;
  localparam logic [11:0] SEL_STRIDE = 12'h008;
  localparam logic [11:0] OFF_SEL_MASK = 12'h004;
  // Command register fields.
  localparam int CMD_START_BIT = 0;
  localparam int CMD_RW_BIT = 1;
  localparam int CMD_WIDTH_LSB = 2;
  localparam int CMD_TYPE_LSB = 4;
  localparam int CMD_MOD_LSB = 6;
  // Select control fields.
  localparam int CTRL_EXT_EN_BIT = 0;
  localparam int CTRL_AUTO_ACK_BIT = 1;
  localparam int CTRL_BE_EN_BIT = 2;
  localparam int CTRL_WAIT_LSB = 4;
  // Select mask fields: base of address bits 31..16, then their don't-care mask.
  localparam int MASK_BASE_LSB = 16;
  // Status fields.
  localparam int STAT_PEND_BIT = 4;
  localparam int STAT_CYC_LSB = 8;
  // Reset values of the select registers.
  localparam logic [31:0] CTRL_RESET = 32'h00000006;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  // Arbitration states.
  typedef enum logic [3:0] {
    ARB_RESET = 4'h1,
    ARB_IMPLICIT = 4'h2,
    ARB_EXPLICIT = 4'h4,
    ARB_EXTERNAL = 4'h8
  } tbsem_arb_t;
  // Bus cycle states of the device end.
  typedef enum logic [5:0] {
    CYC_IDLE = 6'h01,
    CYC_START = 6'h02,
    CYC_DEC1 = 6'h04,
    CYC_DEC2 = 6'h08,
    CYC_SELECT = 6'h10,
    CYC_BEAT = 6'h20
  } tbsem_cyc_t;
  // Partner access states.
  typedef enum logic [3:0] {
    PRT_IDLE = 4'h1,
    PRT_WAIT = 4'h2,
    PRT_START = 4'h4,
    PRT_RUN = 4'h8
  } tbsem_prt_t;
endpackage

// *** tbsem_if.sv ***
// Interface joining the device end and the partner end of the shared bus.
// Assumes undriven lines idle high, as with pull-ups on the board.
`timescale 1ns/1ps
`default_nettype none
interface tbsem_if #(parameter int NUM_SEL = 2) ();
  // Device side drive of the shared access lines.
  tbsem_pkg::tbsem_attr_t dev_attr;
  logic dev_bus_oe;
  logic dev_transfer_start_n;
  logic dev_transfer_in_progress_n;
  // Partner side drive of the shared access lines.
  tbsem_pkg::tbsem_attr_t part_attr;
  logic part_bus_oe;
  logic part_transfer_start_n;
  logic part_transfer_in_progress_n;
  // Resolved shared lines.
  tbsem_pkg::tbsem_attr_t attr;
  logic transfer_start_n;
  logic transfer_in_progress_n;
  logic transfer_ack_n;
  // Acknowledge drive, memory controls and arbitration lines.
  logic ack_out_n;
  logic ack_oe;
  logic [NUM_SEL-1:0] chip_select_n;
  logic [3:0] byte_enable_n;
  logic request_out_n;
  logic bus_driven_out_n;
  logic grant_in_n;
  logic address_strobe_n;
  logic partner_hold_request;
  logic partner_hold_acknowledge;
  // Hold request feeds grant, driven feeds hold acknowledge.
  assign grant_in_n = partner_hold_request;
  assign partner_hold_acknowledge = bus_driven_out_n;
  // Wire resolution from the enables.
  assign attr = dev_bus_oe ? dev_attr : (part_bus_oe ? part_attr : tbsem_pkg::ATTR_IDLE);
  assign transfer_start_n = dev_bus_oe ? dev_transfer_start_n : (part_bus_oe ? part_transfer_start_n : 1'b1);
  assign transfer_in_progress_n = dev_bus_oe ? dev_transfer_in_progress_n :
                                  (part_bus_oe ? part_transfer_in_progress_n : 1'b1);
  assign transfer_ack_n = ack_oe ? ack_out_n : 1'b1;
  modport device (
    input attr, transfer_start_n, transfer_ack_n, grant_in_n, address_strobe_n,
    output dev_attr, dev_bus_oe, dev_transfer_start_n, dev_transfer_in_progress_n,
    output ack_out_n, ack_oe, chip_select_n, byte_enable_n, request_out_n, bus_driven_out_n
  );
  modport partner (
    input transfer_ack_n, partner_hold_acknowledge,
    output part_attr, part_bus_oe, part_transfer_start_n, part_transfer_in_progress_n,
    output partner_hold_request, address_strobe_n
  );
endinterface
`default_nettype wire

// *** tbsem_partner.sv ***
// Partner end: the single outside master that borrows the bus by hold request.
// Assumes the device end on tbsem_if decodes and acknowledges its accesses.
`timescale 1ns/1ps
`default_nettype none
module tbsem_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic need_bus,
  input wire logic start,
  input wire tbsem_pkg::tbsem_attr_t start_attr,
  output logic busy,
  output logic done,
  output logic on_bus,
  tbsem_if.partner bus
);
  tbsem_pkg::tbsem_prt_t state_reg; // Access state.
  tbsem_pkg::tbsem_attr_t attr_reg; // Lines of the running access.
  logic [2:0] beats_reg; // Beats still to be acknowledged.
  logic hold_reg; // Hold request toward the device.
  logic done_reg; // One-cycle completion pulse.

  // Hold is kept while the bus is needed or an access is under way, so it never drops while driving.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= need_bus || start || (state_reg != tbsem_pkg::PRT_IDLE); // [R12] [R20]
    end
  end

  // Access sequence: wait for the bus, one start cycle, then count acknowledged beats.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= tbsem_pkg::PRT_IDLE;
      attr_reg <= tbsem_pkg::ATTR_IDLE;
      beats_reg <= 3'h0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        tbsem_pkg::PRT_IDLE: begin
          // A new access is latched and the hold is raised first.
          if (start) begin
            attr_reg <= start_attr;
            state_reg <= tbsem_pkg::PRT_WAIT; // [R1]
          end
        end
        tbsem_pkg::PRT_WAIT: begin
          // Drive only once hold has been seen and the device is off the bus.
          if (hold_reg && bus.partner_hold_acknowledge) begin
            state_reg <= tbsem_pkg::PRT_START; // [R1]
          end
        end
        tbsem_pkg::PRT_START: begin
          // Start lasts this one cycle only.
          state_reg <= tbsem_pkg::PRT_RUN; // [R5]
          beats_reg <= (attr_reg.width == tbsem_pkg::WIDTH_LINE) ? tbsem_pkg::LINE_BEATS : tbsem_pkg::SINGLE_BEATS;
        end
        tbsem_pkg::PRT_RUN: begin
          // In-progress ends on the edge that takes the last acknowledge.
          if (!bus.transfer_ack_n) begin
            if (beats_reg == 3'h1) begin
              state_reg <= tbsem_pkg::PRT_IDLE; // [R8] [R9]
              done_reg <= 1'b1;
            end else begin
              beats_reg <= beats_reg - 3'h1;
            end
          end
        end
        default: begin
          state_reg <= tbsem_pkg::PRT_IDLE;
        end
      endcase
    end
  end

  // Bus drive follows the access states.
  assign bus.part_bus_oe = (state_reg == tbsem_pkg::PRT_START) || (state_reg == tbsem_pkg::PRT_RUN);
  assign bus.part_attr = attr_reg;
  assign bus.part_transfer_start_n = (state_reg != tbsem_pkg::PRT_START); // [R5]
  assign bus.part_transfer_in_progress_n = !bus.part_bus_oe; // [R8]
  assign bus.partner_hold_request = hold_reg;
  // The address strobe is never used; start alone marks an access.
  assign bus.address_strobe_n = 1'b1; // [R21]
  assign busy = (state_reg != tbsem_pkg::PRT_IDLE);
  assign done = done_reg;
  assign on_bus = bus.part_bus_oe;
endmodule
`default_nettype wire

// *** tbsem_device.sv ***
// Device end: two-wire arbitration, own bus cycles and select decode for partner accesses.
// Assumes software on APB; the partner end sits on tbsem_if.
`timescale 1ns/1ps
`default_nettype none
module tbsem_device #(
  parameter int NUM_SEL = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  tbsem_if.device bus
);
  tbsem_pkg::tbsem_arb_t arb_reg; // Mastership state.
  tbsem_pkg::tbsem_cyc_t cyc_reg; // Bus cycle state.
  tbsem_pkg::tbsem_attr_t own_attr_reg; // Lines of the device's own access.
  tbsem_pkg::tbsem_attr_t cyc_attr_reg; // Lines captured for the running cycle.
  logic pending_reg; // Own access waiting for the bus.
  logic own_cyc_reg; // Running cycle is the device's own.
  logic [2:0] beats_reg; // Beats left in the running cycle.
  logic [3:0] wait_reg; // Wait cycles left before the first beat.
  logic [NUM_SEL-1:0] hit; // Selects matching the captured address.
  logic [NUM_SEL-1:0] hit_reg; // Selects asserted for the running cycle.
  logic [3:0] be_reg; // Active-low byte enables of the running cycle.
  logic ack_drive_reg; // The device drives acknowledge in this cycle.
  logic [31:0] select_control_reg [NUM_SEL]; // Per select enables and wait states.
  logic [31:0] select_mask_reg [NUM_SEL]; // Per select base and don't-care mask.
  logic [31:0] prdata_reg; // Read data, loaded in the setup phase.
  logic grant; // Grant is active.
  logic cyc_idle; // No cycle running.
  logic own_go; // Own cycle starts at this edge.
  logic ext_go; // Partner cycle starts at this edge.
  logic last_beat; // Last beat is acknowledged at this edge.
  logic sel_active; // Select phase or beats.
  logic apb_wr; // APB write in its access phase.
  logic [31:0] rd_data; // Read mux.
  logic rd_hit; // Offset is mapped.
  logic any_auto; // Auto-acknowledge of the hit selects.
  logic any_be; // Byte enables allowed by the hit selects.
  logic [3:0] any_wait; // Wait states of the hit selects.
  logic [3:0] be_calc; // Byte enables from width and address.

  assign grant = !bus.grant_in_n;
  assign cyc_idle = (cyc_reg == tbsem_pkg::CYC_IDLE);
  assign sel_active = (cyc_reg == tbsem_pkg::CYC_SELECT) || (cyc_reg == tbsem_pkg::CYC_BEAT);
  // A partner start is only taken while the device is not explicit master.
  assign ext_go = cyc_idle && !bus.transfer_start_n && (arb_reg != tbsem_pkg::ARB_EXPLICIT) &&
                  (arb_reg != tbsem_pkg::ARB_RESET); // [R11]
  // Own cycles need grant and may start in the cycle right after it appears.
  assign own_go = cyc_idle && pending_reg && grant && bus.transfer_start_n &&
                  (arb_reg != tbsem_pkg::ARB_RESET); // [R19] [R13]
  // All beats of a burst are one bus cycle; this marks its end.
  assign last_beat = (cyc_reg == tbsem_pkg::CYC_BEAT) && !bus.transfer_ack_n && (beats_reg == 3'h1); // [R16]

  // Mastership: grant and pending request decide the state; release waits for the cycle end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_reg <= tbsem_pkg::ARB_RESET; // [R23]
    end else begin
      case (arb_reg)
        tbsem_pkg::ARB_RESET: begin
          arb_reg <= grant ? tbsem_pkg::ARB_IMPLICIT : tbsem_pkg::ARB_EXTERNAL;
        end
        tbsem_pkg::ARB_IMPLICIT: begin
          // Granted without a request the bus stays undriven.
          if (!grant) begin
            arb_reg <= tbsem_pkg::ARB_EXTERNAL;
          end else if (own_go) begin
            arb_reg <= tbsem_pkg::ARB_EXPLICIT; // [R17] [R18]
          end
        end
        tbsem_pkg::ARB_EXTERNAL: begin
          // Grant with a request gives explicit mastership, without one implicit.
          if (own_go) begin
            arb_reg <= tbsem_pkg::ARB_EXPLICIT; // [R13]
          end else if (grant && cyc_idle && !ext_go) begin
            arb_reg <= tbsem_pkg::ARB_IMPLICIT; // [R17]
          end
        end
        tbsem_pkg::ARB_EXPLICIT: begin
          // Mastership holds while granted; a lost grant takes effect at cycle end.
          if (!grant && ((cyc_idle && !own_go) || last_beat)) begin
            arb_reg <= tbsem_pkg::ARB_EXTERNAL; // [R15] [R14]
          end
        end
        default: begin
          arb_reg <= tbsem_pkg::ARB_RESET;
        end
      endcase
    end
  end

  // Select decode per select; partner hits also need the select's enable.
  for (genvar i = 0; i < NUM_SEL; i++) begin : g_sel
    localparam logic [11:0] CTRL_OFF = 12'(tbsem_pkg::OFF_SEL_BASE + tbsem_pkg::SEL_STRIDE * 12'(i));
    assign hit[i] = (((cyc_attr_reg.addr[31:16] ^ select_mask_reg[i][31:tbsem_pkg::MASK_BASE_LSB]) &
                    ~select_mask_reg[i][15:0]) == 16'h0000) &&
                    (own_cyc_reg || select_control_reg[i][tbsem_pkg::CTRL_EXT_EN_BIT]); // [R22]
    // Software writes to this select's registers.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        select_control_reg[i] <= tbsem_pkg::CTRL_RESET;
        select_mask_reg[i] <= tbsem_pkg::MASK_RESET;
      end else if (apb_wr && paddr == CTRL_OFF) begin
        select_control_reg[i] <= pwdata;
      end else if (apb_wr && paddr == 12'(CTRL_OFF + tbsem_pkg::OFF_SEL_MASK)) begin
        select_mask_reg[i] <= pwdata;
      end
    end
  end

  // Settings merged over the hit selects, and byte enables from width and address.
  always_comb begin
    any_auto = 1'b0;
    any_be = 1'b0;
    any_wait = 4'h0;
    for (int j = 0; j < NUM_SEL; j++) begin
      if (hit[j]) begin
        any_auto = any_auto | select_control_reg[j][tbsem_pkg::CTRL_AUTO_ACK_BIT];
        any_be = any_be | select_control_reg[j][tbsem_pkg::CTRL_BE_EN_BIT];
        any_wait = any_wait | select_control_reg[j][tbsem_pkg::CTRL_WAIT_LSB +: 4];
      end
    end
    case (cyc_attr_reg.width)
      tbsem_pkg::WIDTH_BYTE: be_calc = ~(4'h8 >> cyc_attr_reg.addr[1:0]);
      tbsem_pkg::WIDTH_WORD: be_calc = cyc_attr_reg.addr[1] ? 4'hC : 4'h3;
      default: be_calc = 4'h0;
    endcase
  end

  // Bus cycle: start (own only), two decode cycles, select with waits, then beats.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_reg <= tbsem_pkg::CYC_IDLE;
      cyc_attr_reg <= tbsem_pkg::ATTR_IDLE;
      own_cyc_reg <= 1'b0;
      beats_reg <= 3'h0;
      wait_reg <= 4'h0;
      hit_reg <= '0;
      be_reg <= 4'hF;
      ack_drive_reg <= 1'b0;
    end else begin
      case (cyc_reg)
        tbsem_pkg::CYC_IDLE: begin
          // Partner lines are captured here once and ignored for the rest of the burst.
          if (ext_go) begin
            cyc_attr_reg <= bus.attr; // [R4]
            own_cyc_reg <= 1'b0;
            cyc_reg <= tbsem_pkg::CYC_DEC1;
          end else if (own_go) begin
            cyc_attr_reg <= own_attr_reg;
            own_cyc_reg <= 1'b1;
            cyc_reg <= tbsem_pkg::CYC_START; // [R14]
          end
        end
        tbsem_pkg::CYC_START: begin
          cyc_reg <= tbsem_pkg::CYC_DEC1;
        end
        tbsem_pkg::CYC_DEC1: begin
          cyc_reg <= tbsem_pkg::CYC_DEC2;
        end
        tbsem_pkg::CYC_DEC2: begin
          // A partner access that hits no enabled select is left alone.
          if (own_cyc_reg || (|hit)) begin
            cyc_reg <= tbsem_pkg::CYC_SELECT; // [R6]
            hit_reg <= hit;
            wait_reg <= any_wait;
            be_reg <= any_be ? be_calc : 4'hF; // [R22]
            ack_drive_reg <= own_cyc_reg || any_auto;
            beats_reg <= (cyc_attr_reg.width == tbsem_pkg::WIDTH_LINE) ? tbsem_pkg::LINE_BEATS :
                         tbsem_pkg::SINGLE_BEATS; // [R3]
          end else begin
            cyc_reg <= tbsem_pkg::CYC_IDLE;
            own_cyc_reg <= 1'b0;
          end
        end
        tbsem_pkg::CYC_SELECT: begin
          // With no wait states the first acknowledge comes in the next cycle.
          if (wait_reg == 4'h0) begin
            cyc_reg <= tbsem_pkg::CYC_BEAT; // [R7]
          end else begin
            wait_reg <= wait_reg - 4'h1;
          end
        end
        tbsem_pkg::CYC_BEAT: begin
          // Each acknowledged beat counts; selects and acknowledge drop after the last.
          if (!bus.transfer_ack_n) begin
            if (beats_reg == 3'h1) begin
              cyc_reg <= tbsem_pkg::CYC_IDLE; // [R9] [R10]
              own_cyc_reg <= 1'b0;
              ack_drive_reg <= 1'b0;
              hit_reg <= '0;
            end else begin
              beats_reg <= beats_reg - 3'h1; // [R7]
            end
          end
        end
        default: begin
          cyc_reg <= tbsem_pkg::CYC_IDLE;
        end
      endcase
    end
  end

  // Own access request: set by a command write, cleared when its cycle starts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 1'b0;
      own_attr_reg <= tbsem_pkg::ATTR_IDLE;
    end else begin
      if (apb_wr && paddr == tbsem_pkg::OFF_CMD && !pending_reg && !own_cyc_reg) begin
        own_attr_reg.rw <= pwdata[tbsem_pkg::CMD_RW_BIT];
        own_attr_reg.width <= pwdata[tbsem_pkg::CMD_WIDTH_LSB +: 2];
        own_attr_reg.ttype <= pwdata[tbsem_pkg::CMD_TYPE_LSB +: 2];
        own_attr_reg.tmod <= pwdata[tbsem_pkg::CMD_MOD_LSB +: 3];
        pending_reg <= pwdata[tbsem_pkg::CMD_START_BIT];
      end else if (own_go) begin
        pending_reg <= 1'b0;
      end
      if (apb_wr && paddr == tbsem_pkg::OFF_ADDR && !pending_reg && !own_cyc_reg) begin
        own_attr_reg.addr <= pwdata;
      end
    end
  end

  // APB read mux; select registers are found by walking the selects.
  always_comb begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      tbsem_pkg::OFF_CMD: rd_data = {23'h000000, own_attr_reg.tmod, own_attr_reg.ttype, own_attr_reg.width,
                                     own_attr_reg.rw, pending_reg};
      tbsem_pkg::OFF_ADDR: rd_data = own_attr_reg.addr;
      tbsem_pkg::OFF_STATUS: rd_data = {18'h00000, cyc_reg, 3'h0, pending_reg, arb_reg};
      default: begin
        rd_hit = 1'b0;
        for (int k = 0; k < NUM_SEL; k++) begin
          if (paddr == 12'(tbsem_pkg::OFF_SEL_BASE + tbsem_pkg::SEL_STRIDE * 12'(k))) begin
            rd_data = select_control_reg[k];
            rd_hit = 1'b1;
          end
          if (paddr == 12'(tbsem_pkg::OFF_SEL_BASE + tbsem_pkg::SEL_STRIDE * 12'(k) + tbsem_pkg::OFF_SEL_MASK)) begin
            rd_data = select_mask_reg[k];
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  // Read data is loaded in the setup phase so it stands through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata_reg <= rd_data;
    end
  end

  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_hit;
  assign prdata = prdata_reg;

  // Bus drive: only the explicit master drives lines and driven; during partner access both stay off.
  assign bus.dev_bus_oe = (arb_reg == tbsem_pkg::ARB_EXPLICIT); // [R14] [R17] [R23]
  assign bus.bus_driven_out_n = (arb_reg != tbsem_pkg::ARB_EXPLICIT); // [R2] [R13]
  assign bus.dev_attr = own_attr_reg;
  assign bus.dev_transfer_start_n = (cyc_reg != tbsem_pkg::CYC_START); // [R14]
  assign bus.dev_transfer_in_progress_n = !(own_cyc_reg && !cyc_idle);
  // Request stays inactive while a partner cycle runs.
  assign bus.request_out_n = !(pending_reg && (arb_reg != tbsem_pkg::ARB_EXPLICIT) &&
                               (cyc_idle || own_cyc_reg)); // [R2]
  // Selects and byte enables stand from the select phase through the last beat.
  assign bus.chip_select_n = ~(hit_reg & {NUM_SEL{sel_active}}); // [R6] [R8]
  assign bus.byte_enable_n = sel_active ? be_reg : 4'hF; // [R8] [R10]
  assign bus.ack_oe = ack_drive_reg && sel_active; // [R22]
  assign bus.ack_out_n = (cyc_reg != tbsem_pkg::CYC_BEAT); // [R7]
endmodule
`default_nettype wire

// *** tbsem_chk_assertions.sv ***
// Checker for the shared bus lines between the device end and the partner end.
// Assumes it is instantiated beside tbsem_if with zero wait states programmed.
`timescale 1ns/1ps
`default_nettype none
module tbsem_chk #(parameter int NUM_SEL = 2) (
  input wire logic pclk,
  input wire logic presetn,
  input wire tbsem_pkg::tbsem_attr_t attr,
  input wire logic transfer_start_n,
  input wire logic transfer_ack_n,
  input wire logic transfer_in_progress_n,
  input wire logic [NUM_SEL-1:0] chip_select_n,
  input wire logic [3:0] byte_enable_n,
  input wire logic bus_driven_out_n,
  input wire logic grant_in_n,
  input wire logic dev_bus_oe,
  input wire logic part_bus_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Four acknowledged beats followed by a released acknowledge.
  sequence s_four_beats;
    !transfer_ack_n [*4] ##1 transfer_ack_n;
  endsequence
  AST_ONE_DRIVER: assert property (!(dev_bus_oe && part_bus_oe))
    else $error("both ends drive the bus");
  AST_HOLD_QUIET: assert property (part_bus_oe |-> bus_driven_out_n)
    else $error("driven active in partner access");
  AST_SEL_C4: assert property ($fell(&chip_select_n) |-> $past(transfer_start_n, 3) == 1'b0)
    else $error("select not three cycles after start");
  AST_ACK_C5: assert property ($fell(transfer_ack_n) |-> $past(!(&chip_select_n)))
    else $error("early acknowledge");
  AST_LINE_BEATS: assert property ($fell(transfer_ack_n) && attr.width == tbsem_pkg::WIDTH_LINE
      |-> s_four_beats) else $error("line access not four beats");
  AST_SINGLE_BEAT: assert property ($fell(transfer_ack_n) && attr.width != tbsem_pkg::WIDTH_LINE
      |-> ##1 transfer_ack_n) else $error("single access not one beat");
  AST_SEL_HELD: assert property (!transfer_ack_n |-> !(&chip_select_n) && !(&byte_enable_n))
    else $error("select dropped in a beat");
  AST_RELEASE: assert property ($rose(transfer_ack_n)
      |-> &chip_select_n && &byte_enable_n && transfer_in_progress_n) else $error("lines not released after last beat");
  AST_DRIVEN_RELEASE: assert property ($rose(bus_driven_out_n) |-> $past(grant_in_n) && !dev_bus_oe)
    else $error("bus released without grant removal");
  AST_DRIVEN_START: assert property ($fell(bus_driven_out_n)
      |-> !transfer_start_n && dev_bus_oe && $past(!grant_in_n)) else $error("mastership taken badly");
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Testbench joining both ends over tbsem_if and driving APB and the partner user side.
// Assumes pready answers within the bounded wait and select 0 hits address zero.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic need_bus = 1'b0, start = 1'b0, pready, pslverr, busy, done, on_bus, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, r;
  tbsem_pkg::tbsem_attr_t start_attr = tbsem_pkg::ATTR_IDLE;
  int n_mismatch = 0, cmp_count = 0, acks = 0, a0 = 0;
  tbsem_if #(.NUM_SEL(2)) bif ();
  tbsem_device #(.NUM_SEL(2)) i_tbsem_device (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bif));
  tbsem_partner i_tbsem_partner (.pclk(pclk), .presetn(presetn), .need_bus(need_bus), .start(start),
    .start_attr(start_attr), .busy(busy), .done(done), .on_bus(on_bus), .bus(bif));
  tbsem_chk #(.NUM_SEL(2)) u_chk (.pclk(pclk), .presetn(presetn), .attr(bif.attr),
    .transfer_start_n(bif.transfer_start_n), .transfer_ack_n(bif.transfer_ack_n),
    .transfer_in_progress_n(bif.transfer_in_progress_n),
    .chip_select_n(bif.chip_select_n), .byte_enable_n(bif.byte_enable_n), .bus_driven_out_n(bif.bus_driven_out_n),
    .grant_in_n(bif.grant_in_n), .dev_bus_oe(bif.dev_bus_oe), .part_bus_oe(bif.part_bus_oe));
  always #12.5 pclk = ~pclk;
  // Counts acknowledged beats on the shared line.
  always @(posedge pclk) if (bif.transfer_ack_n === 1'b0) acks <= acks + 1;
  task stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One APB transfer; read data and error taken at the edge where pready is high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    r = prdata; err = pslverr;
    if (k >= 50) begin n_mismatch++; stop_test; end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Partner access of width w, expecting n acknowledged beats.
  task part(input logic [1:0] w, input int n);
    int k;
    a0 = acks; start_attr <= '{32'h0, 1'b1, w, 2'h0, 3'h0}; start <= 1'b1;
    @(posedge pclk) start <= 1'b0;
    k = 0;
    do begin @(posedge pclk); k++; end while (done !== 1'b1 && k < 40);
    if (k >= 40) begin n_mismatch++; stop_test; end
    @(posedge pclk) chk(32'(acks - a0), 32'(n));
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk) chk(32'(bif.bus_driven_out_n), 32'h1);
    apb(1'b0, tbsem_pkg::OFF_STATUS, 32'h0); chk(32'(r[3:0]), 32'h2);
    chk(32'(bif.dev_bus_oe), 32'h0);
    apb(1'b0, tbsem_pkg::OFF_SEL_BASE, 32'h0); chk(r, tbsem_pkg::CTRL_RESET);
    apb(1'b0, 12'hFFC, 32'h0); chk(32'(err), 32'h1);
    $display("test reset done");
    apb(1'b1, tbsem_pkg::OFF_SEL_BASE, 32'h7);
    part(tbsem_pkg::WIDTH_LINE, 4);
    part(tbsem_pkg::WIDTH_LONG, 1);
    // Two wait states on select 0, then a byte access through it.
    apb(1'b1, tbsem_pkg::OFF_SEL_BASE, 32'h27);
    part(tbsem_pkg::WIDTH_BYTE, 1);
    $display("test partner done");
    apb(1'b1, tbsem_pkg::OFF_ADDR, 32'h100);
    a0 = acks;
    apb(1'b1, tbsem_pkg::OFF_CMD, 32'hD);
    need_bus <= 1'b1;
    // Poll status until the own cycle is over; running out of polls is a failure.
    for (int k = 0; k < 40 && (r[4] !== 1'b0 || r[13:8] !== 6'h01 || k == 0); k++) begin
      apb(1'b0, tbsem_pkg::OFF_STATUS, 32'h0);
      if (k == 39 && (r[4] !== 1'b0 || r[13:8] !== 6'h01)) begin
        n_mismatch++;
        stop_test;
      end
    end
    chk(32'(acks - a0), 32'h4);
    chk(32'(bif.bus_driven_out_n), 32'h1);
    chk(32'(r[3:0]), 32'h8);
    need_bus <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, tbsem_pkg::OFF_STATUS, 32'h0); chk(32'(r[3:0]), 32'h2);
    $display("test own access done");
    stop_test;
  end
endmodule
`default_nettype wire
